// *** design/arfr_pkg.sv ***
// package of register map, field layout and encodings for the converter result formatter
package arfr_pkg;
    // ***************************************************************
    // register byte addresses (chosen map, one aligned word each)
    // ***************************************************************
    localparam logic [7:0] ARFR_OFF_SELECT = 8'h00;
    localparam logic [7:0] ARFR_OFF_RESULT_LOW = 8'h04;
    localparam logic [7:0] ARFR_OFF_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ARFR_OFF_CONTROL = 8'h0C;
    localparam logic [7:0] ARFR_OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ARFR_OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] ARFR_OFF_INPUT = 8'h18;
    localparam logic [7:0] ARFR_OFF_ACTIVE_REF = 8'h1C;

    // ***************************************************************
    // field positions and reset values
    // ***************************************************************
    localparam int ARFR_REF_HI = 7;
    localparam int ARFR_REF_LO = 6;
    localparam int ARFR_ALIGN_BIT = 5;
    localparam int ARFR_CHAN_HI = 4;
    localparam logic [7:0] ARFR_SELECT_RESET = 8'h00;
    localparam int ARFR_CTL_START = 0;
    localparam int ARFR_CTL_DIFF = 1;
    localparam int ARFR_CTL_BUSY = 2;
    localparam int ARFR_IRQ_DONE = 0;
    localparam int ARFR_RES_W = 10;
    localparam int ARFR_INPUT_W = 16;

    // ***************************************************************
    // encodings and code limits
    // ***************************************************************
    localparam logic [1:0] ARFR_REF_EXTERNAL = 2'b00;
    localparam logic [1:0] ARFR_REF_SUPPLY = 2'b01;
    localparam logic [1:0] ARFR_REF_RESERVED = 2'b10;
    localparam logic [1:0] ARFR_REF_INTERNAL = 2'b11;
    localparam logic [9:0] ARFR_SE_MIN = 10'h000;
    localparam logic [9:0] ARFR_SE_MAX = 10'h3FF;
    localparam logic signed [10:0] ARFR_DIFF_MIN = -11'sd512;
    localparam logic signed [10:0] ARFR_DIFF_MAX = 11'sd511;
    localparam int ARFR_CONV_CYCLES = 13;

    typedef enum logic [1:0] {
        ARFR_IDLE = 2'b01,
        ARFR_CONVERT = 2'b10
    } arfr_state_e;
endpackage : arfr_pkg

// *** design/arfr_top.sv ***
// result formatting, reference selection and register slave of a 10-bit converter
// How it works
// RQ1 - result readable in low and high result bytes once done flag is set
// RQ2 - single-ended code is input times 1024 over reference, unsigned
// RQ3 - single-ended 0x000 is ground, 0x3FF is reference minus one step
// RQ4 - differential code is difference times gain times 512 over reference
// RQ5 - differential codes are two's complement 0x200..0x1FF, saturating at limits
// RQ6 - top result bit in high byte is the sign of differential results
// RQ7 - reference field: 00 external pin, 01 supply, 10 reserved, 11 internal
// RQ8 - reference field writes during conversion apply only when it completes
// RQ9 - alignment bit 5: one left-aligned, zero right-aligned
// RQ10 - alignment change re-maps stored result at once
// RQ11 - software keeps internal references off while external reference is driven
// RQ12 - software keeps port pins quiet while a conversion runs
// RQ13 - done flag set when conversion finishes and result registers update
// RQ14 - left: bits 9:2 high, 1:0 top of low; right: 9:8 low of high
module arfr_top
    import arfr_pkg::*;
#(
    parameter int CONV_CYCLES = ARFR_CONV_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic [1:0] reference_source_field
);
    initial begin
        if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin
            $error("conversion length out of range");
        end
    end

    // ***************************************************************
    // helper functions
    // ***************************************************************
    // scale a signed fraction of reference; ratio held as input/ref with 16-bit fraction
    function automatic logic [9:0] fmt_code(input logic diff, input logic signed [15:0] sample);
        logic signed [16:0] scaled;
        scaled = 17'(sample) >>> 6;
        if (diff) begin
            if (scaled > 17'(ARFR_DIFF_MAX)) begin
                fmt_code = ARFR_DIFF_MAX[9:0]; // see RQ5
            end else if (scaled < 17'(ARFR_DIFF_MIN)) begin
                fmt_code = ARFR_DIFF_MIN[9:0]; // see RQ5
            end else begin
                fmt_code = scaled[9:0]; // see RQ4 see RQ6
            end
        end else begin
            // sample is unsigned fraction of reference: code = vin*1024/vref
            fmt_code = sample[15:6]; // see RQ2 see RQ3
        end
    endfunction : fmt_code

    function automatic logic [15:0] align_word(input logic left, input logic [9:0] res);
        if (left) begin
            align_word = {res, 6'b00_0000}; // see RQ14
        end else begin
            align_word = {6'b00_0000, res}; // see RQ14
        end
    endfunction : align_word

    // ***************************************************************
    // state
    // ***************************************************************
    arfr_state_e state, next_state;
    logic [7:0] select_reg, next_select_reg;
    logic [1:0] active_ref, next_active_ref;
    logic [9:0] result, next_result;
    logic [7:0] count, next_count;
    logic diff_mode, next_diff_mode;
    logic conv_diff, next_conv_diff;
    logic [15:0] sample_in, next_sample_in;
    logic irq_status, next_irq_status;
    logic irq_mask, next_irq_mask;
    logic [31:0] rdata, next_rdata;
    logic ph_valid, next_ph_valid;
    logic ph_write, next_ph_write;
    logic [7:0] ph_addr, next_ph_addr;

    wire logic addr_phase = hsel && hready && htrans[1];
    wire logic wr_en = ph_valid && ph_write;
    wire logic conv_done = (state == ARFR_CONVERT) && (count == 8'(CONV_CYCLES - 1));
    wire logic [15:0] aligned = align_word(select_reg[ARFR_ALIGN_BIT], result); // see RQ10

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata;
    assign irq = irq_status && irq_mask;
    assign reference_source_field = active_ref;

    // ***************************************************************
    // bus slave: address phase capture and read data
    // ***************************************************************
    // zero-wait slave; read data registered so it stands in the data phase
    always_comb begin
        next_ph_valid = addr_phase;
        next_ph_write = hwrite;
        next_ph_addr = {haddr[7:2], 2'b00};
        next_rdata = rdata;
        if (addr_phase && !hwrite) begin
            unique case ({haddr[7:2], 2'b00})
                ARFR_OFF_SELECT: next_rdata = {24'h00_0000, select_reg};
                ARFR_OFF_RESULT_LOW: next_rdata = {24'h00_0000, aligned[7:0]}; // see RQ1
                ARFR_OFF_RESULT_HIGH: next_rdata = {24'h00_0000, aligned[15:8]}; // see RQ1
                ARFR_OFF_CONTROL: next_rdata = {29'h0, state == ARFR_CONVERT, diff_mode, 1'b0};
                ARFR_OFF_IRQ_STATUS: next_rdata = {31'h0, irq_status};
                ARFR_OFF_IRQ_MASK: next_rdata = {31'h0, irq_mask};
                ARFR_OFF_INPUT: next_rdata = {16'h0000, sample_in};
                ARFR_OFF_ACTIVE_REF: next_rdata = {30'h0, active_ref};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
            rdata <= 32'h0000_0000;
        end else begin
            ph_valid <= next_ph_valid;
            ph_write <= next_ph_write;
            ph_addr <= next_ph_addr;
            rdata <= next_rdata;
        end
    end

    // ***************************************************************
    // registers, conversion sequencer and completion flag
    // ***************************************************************
    // the reference lock keeps a mid-conversion write from disturbing sampling
    always_comb begin
        next_state = state;
        next_select_reg = select_reg;
        next_active_ref = active_ref;
        next_result = result;
        next_count = count;
        next_diff_mode = diff_mode;
        next_conv_diff = conv_diff;
        next_sample_in = sample_in;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        if (wr_en) begin
            unique case (ph_addr)
                ARFR_OFF_SELECT: next_select_reg = hwdata[7:0];
                ARFR_OFF_IRQ_MASK: next_irq_mask = hwdata[ARFR_IRQ_DONE];
                ARFR_OFF_INPUT: next_sample_in = hwdata[ARFR_INPUT_W-1:0];
                ARFR_OFF_IRQ_STATUS: begin
                    if (hwdata[ARFR_IRQ_DONE]) begin
                        next_irq_status = 1'b0;
                    end
                end
                ARFR_OFF_CONTROL: next_diff_mode = hwdata[ARFR_CTL_DIFF];
                default: begin
                end
            endcase
        end
        // reference follows the field whenever idle
        if (state == ARFR_IDLE) begin
            next_active_ref = next_select_reg[ARFR_REF_HI:ARFR_REF_LO]; // see RQ7 see RQ8
        end
        unique case (state)
            ARFR_IDLE: begin
                if (wr_en && ph_addr == ARFR_OFF_CONTROL && hwdata[ARFR_CTL_START]) begin
                    next_state = ARFR_CONVERT;
                    next_count = 8'h00;
                    next_conv_diff = hwdata[ARFR_CTL_DIFF];
                end
            end
            ARFR_CONVERT: begin
                next_count = count + 8'h01;
                if (conv_done) begin
                    next_state = ARFR_IDLE;
                    next_result = fmt_code(conv_diff, sample_in);
                    next_irq_status = 1'b1; // see RQ13, set wins over clear
                    next_active_ref = next_select_reg[ARFR_REF_HI:ARFR_REF_LO]; // see RQ8
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ARFR_IDLE;
            select_reg <= ARFR_SELECT_RESET;
            active_ref <= ARFR_REF_EXTERNAL;
            result <= ARFR_SE_MIN;
            count <= 8'h00;
            diff_mode <= 1'b0;
            conv_diff <= 1'b0;
            sample_in <= 16'h0000;
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
        end else begin
            state <= next_state;
            select_reg <= next_select_reg;
            active_ref <= next_active_ref;
            result <= next_result;
            count <= next_count;
            diff_mode <= next_diff_mode;
            conv_diff <= next_conv_diff;
            sample_in <= next_sample_in;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end
endmodule : arfr_top

// *** bench/arfr_ref_model.sv ***
// behavioural model of the reference sources behind the select field
module arfr_ref_model #(
    parameter int EXT_MV = 3000,
    parameter int SUPPLY_MV = 3300
) (
    input wire logic hclk,
    input wire logic [1:0] reference_source_field,
    input wire logic ext_ref,
    output logic [11:0] vref_mv,
    output logic fault
);
    // reserved code leaves no source, so the model reads zero volts
    always_comb begin
        case (reference_source_field)
            2'b00: vref_mv = 12'(EXT_MV);
            2'b01: vref_mv = 12'(SUPPLY_MV);
            2'b11: vref_mv = 12'hA00;
            default: vref_mv = 12'h000;
        endcase
    end
    // an internal source against a driven external pin shorts them
    always_ff @(posedge hclk) fault <= ext_ref && reference_source_field != 2'b00;
endmodule : arfr_ref_model

// *** bench/arfr_props.sv ***
// port-side checker of bus answers, result layout, reference lock and interrupt
module arfr_props
    import arfr_pkg::*;
#(
    parameter int CONV_CYCLES = 13
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq,
    input wire logic [1:0] reference_source_field
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic wr_dp, rd_dp, mask_q, align_q;
    logic [7:0] a_q, cnt;
    wire aph = hsel && hready && htrans[1];
    // shadow of mask, alignment and conversion count, rebuilt from bus traffic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_dp, rd_dp, mask_q, align_q, a_q, cnt} <= '0;
        end else begin
            wr_dp <= aph && hwrite;
            rd_dp <= aph && !hwrite;
            if (aph) a_q <= haddr[7:0];
            if (wr_dp && a_q == ARFR_OFF_IRQ_MASK) mask_q <= hwdata[0];
            if (wr_dp && a_q == ARFR_OFF_SELECT) align_q <= hwdata[ARFR_ALIGN_BIT];
            if (wr_dp && a_q == ARFR_OFF_CONTROL && hwdata[0] && cnt == 8'h00) cnt <= 8'(CONV_CYCLES);
            else if (cnt != 8'h00) cnt <= cnt - 8'h01;
        end
    end
    // ***************************************************************
    // properties
    // ***************************************************************
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus slave stalled or erred");
    property p_hold; !rd_dp |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_unmap; rd_dp && a_q[7:5] != 3'h0 |-> hrdata == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_left; rd_dp && align_q && a_q == ARFR_OFF_RESULT_LOW |-> hrdata[5:0] == '0; endproperty
    a_left: assert property (p_left) else $error("left low byte has stray bits");
    property p_right; rd_dp && !align_q && a_q == ARFR_OFF_RESULT_HIGH |-> hrdata[31:2] == '0; endproperty
    a_right: assert property (p_right) else $error("right high byte has stray bits");
    property p_lock; cnt > 8'h02 |=> $stable(reference_source_field); endproperty
    a_lock: assert property (p_lock) else $error("reference moved mid conversion");
    property p_done; cnt == 8'h01 && mask_q |-> ##[0:1] irq; endproperty
    a_done: assert property (p_done) else $error("no interrupt at completion");
    property p_mask; !mask_q |-> !irq; endproperty
    a_mask: assert property (p_mask) else $error("interrupt while masked");
endmodule : arfr_props
bind arfr_top arfr_props #(.CONV_CYCLES(CONV_CYCLES)) arfr_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .reference_source_field);

// *** bench/tb.sv ***
// self-checking bench of the converter result formatter
module tb
    import arfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_ref = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
    logic [1:0] htrans = '0, ref_f;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irq, fault;
    logic [11:0] vref_mv;
    int error_cnt = 0, cmp_count = 0;
    always #5 hclk = ~hclk;
    arfr_top #(.CONV_CYCLES(13)) arfr_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .reference_source_field(ref_f));
    arfr_ref_model arfr_ref_model_inst (.hclk, .reference_source_field(ref_f), .ext_ref, .vref_mv, .fault);
    // ***************************************************************
    // bus and compare helpers
    // ***************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single word transfer; waits on hready, the watchdog bounds a hang
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, '0);
        chk(d, e);
    endtask : rc
    task automatic wait_done;
        for (int n = 0; n < 40 && d[0] !== 1'b1; n++) bus(1'b0, ARFR_OFF_IRQ_STATUS, '0);
        chk(d, 32'h0000_0001);
    endtask : wait_done
    // both alignments of one stored code
    task automatic res(input logic [1:0] rf, input logic [9:0] c);
        wr(ARFR_OFF_SELECT, {24'h00_0000, rf, 6'h20});
        rc(ARFR_OFF_RESULT_HIGH, {24'h00_0000, c[9:2]});
        rc(ARFR_OFF_RESULT_LOW, {24'h00_0000, c[1:0], 6'h00});
        wr(ARFR_OFF_SELECT, {24'h00_0000, rf, 6'h00});
        rc(ARFR_OFF_RESULT_HIGH, {30'h0000_0000, c[9:8]});
        rc(ARFR_OFF_RESULT_LOW, {24'h00_0000, c[7:0]});
    endtask : res
    task automatic t_code(input logic diff, input logic [15:0] inp, input logic [9:0] c);
        wr(ARFR_OFF_INPUT, {16'h0000, inp});
        wr(ARFR_OFF_CONTROL, {30'h0000_0000, diff, 1'b1});
        d = '0;
        wait_done();
        res(2'b01, c);
        wr(ARFR_OFF_IRQ_STATUS, 32'h0000_0001);
    endtask : t_code
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_reset;
        rc(ARFR_OFF_SELECT, '0);
        rc(ARFR_OFF_ACTIVE_REF, '0);
        wr(8'h20, 32'hFFFF_FFFF);
        rc(8'h20, '0);
        for (int i = 0; i < 4; i++) begin
            wr(ARFR_OFF_SELECT, 32'(i) << 6);
            rc(ARFR_OFF_ACTIVE_REF, 32'(i));
            chk({30'h0000_0000, ref_f}, 32'(i));
        end
    endtask : t_reset
    // reference write while busy waits; alignment change acts at once
    task automatic t_lock;
        wr(ARFR_OFF_SELECT, 32'h0000_0040);
        wr(ARFR_OFF_INPUT, 32'h0000_4000);
        wr(ARFR_OFF_CONTROL, 32'h0000_0001);
        wr(ARFR_OFF_SELECT, 32'h0000_00E0);
        rc(ARFR_OFF_ACTIVE_REF, 32'h0000_0001);
        rc(ARFR_OFF_RESULT_HIGH, 32'h0000_009C);
        d = '0;
        wait_done();
        rc(ARFR_OFF_ACTIVE_REF, 32'h0000_0003);
        res(2'b11, 10'h100);
    endtask : t_lock
    // status left set by the last conversion drives irq through the mask
    task automatic t_irq;
        wr(ARFR_OFF_IRQ_MASK, 32'h0000_0001);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(ARFR_OFF_IRQ_MASK, 32'h0000_0000);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(ARFR_OFF_IRQ_MASK, 32'h0000_0001);
        wr(ARFR_OFF_IRQ_STATUS, 32'h0000_0001);
        rc(ARFR_OFF_IRQ_STATUS, '0);
        t_code(1'b0, 16'h0040, 10'h001);
    endtask : t_irq
    // external source driven while the field selects the pin: the model must not flag a short
    task automatic t_extref;
        wr(ARFR_OFF_SELECT, 32'h0000_0000);
        ext_ref <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({31'h0000_0000, fault}, '0);
        chk({30'h0000_0000, ref_f}, {30'h0000_0000, ARFR_REF_EXTERNAL});
        ext_ref <= 1'b0;
    endtask : t_extref
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_code(1'b0, 16'h0000, 10'h000);
        t_code(1'b0, 16'hFFFF, 10'h3FF);
        t_code(1'b0, 16'h8040, 10'h201);
        t_code(1'b1, 16'h8000, 10'h200);
        t_code(1'b1, 16'h7FFF, 10'h1FF);
        t_code(1'b1, 16'h9C00, 10'h270);
        t_lock();
        t_irq();
        t_extref();
        chk({31'h0000_0000, fault}, '0);
        finish_test();
    end
    // watchdog: the full sequence needs well under 2000 cycles
    initial begin
        #50000;
        error_cnt++;
        finish_test();
    end
endmodule : tb
